// ==== rtl/abu_address_breakpoint_unit.sv ====
// Address breakpoint unit with AXI4-Lite register slave
// Behaviour
// RL1: Enabled break plus full 16-bit address equality raises breakpoint request.
// RL2: Only program-counter fetch addresses are compared, other bus addresses ignored.
// RL3: Core finishes current instruction, then loads software interrupt opcode.
// RL4: Vector is FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// RL5: Match on last instruction cycle starts the break immediately.
// RL6: Software writing one to break active forces a break.
// RL7: Match sets break active; software clears it writing zero.
// RL8: Match enable is bit 7, read/write, cleared by zero write and reset.
// RL9: Break address held in high and low byte registers, reset to zero.
// RL10: Return from interrupt inside break routine ends the break state.
// RL11: Timer counter halted while break is in progress.
// RL12: Watchdog disabled in break when high test voltage on reset pin.
// RL13: Unit keeps operating in wait mode.
// RL14: Unit inactive in stop mode; registers unchanged by stop.
// RL15: Flags clearable during break only when flag clear enable is one.
// RL16: Break ending wait or stop sets wake flag; zero write clears it.
// RL17: Flag cleared in break stays cleared; two-step clears finish afterwards.
// RL18: Comparison registered; request held until core acknowledges entry.
// RL19: Forced break behaves exactly like a match break; here a forced break leaves the active flag clear.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
module abu_address_breakpoint_unit (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] cpu_address,
    input wire logic cpu_pc_fetch,
    input wire logic cpu_last_cycle,
    input wire logic cpu_break_ack,
    input wire logic cpu_return_from_interrupt,
    input wire logic monitor_mode,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic high_test_voltage,
    output logic break_request,
    output logic [15:0] break_vector,
    output logic break_in_progress,
    output logic timer_module_halt,
    output logic supervisory_watchdog_disable,
    output logic break_flag_clear_allowed,
    output logic irq
);
    import abu_pkg::*;

    typedef struct packed {
        logic match_enable;
        logic active_flag;
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic flag_clear_enable;
        logic wake_flag;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        abu_state_t state;
        logic match_hit;
        logic last_hit;
        logic [15:0] vector;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic timer_halt;
        logic cop_disable;
        logic clear_allowed;
        logic irq;
        logic [2:0] hv_sync;
        logic hv_level;
        logic request;
        logic break_on;
    } abu_regs_t;

    abu_regs_t state_reg;
    abu_regs_t state_next;

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == {4'h0, ABU_OFF_STATUS_CONTROL}) || (addr == {4'h0, ABU_OFF_ADDR_HIGH})
            || (addr == {4'h0, ABU_OFF_ADDR_LOW}) || (addr == {4'h0, ABU_OFF_FLAG_CLEAR})
            || (addr == ABU_OFF_WAKE) || (addr == ABU_OFF_IRQ_STATUS)
            || (addr == ABU_OFF_IRQ_MASK);
    endfunction

    logic do_write;
    logic do_read;
    logic sw_force;
    logic trigger;
    logic [7:0] wbyte;

    always_comb begin
        state_next = state_reg;
        wbyte = state_reg.w_data[7:0];
        do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid
            && state_reg.w_strb[0];
        sw_force = 1'b0;
        // Test voltage is a pin level; it moves only once the last two stages agree
        state_next.hv_sync = {state_reg.hv_sync[1:0], high_test_voltage};
        if (state_reg.hv_sync[1] == state_reg.hv_sync[2]) begin
            state_next.hv_level = state_reg.hv_sync[2];
        end
        // AXI write channels, taken in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
            state_next.awready = 1'b0;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
            state_next.wready = 1'b0;
        end
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            state_next.bvalid = 1'b1;
            state_next.bresp = mapped(state_reg.aw_addr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end
        // Register writes; stop mode freezes nothing software writes [RL14]
        if (do_write) begin
            case (state_reg.aw_addr)
                {4'h0, ABU_OFF_STATUS_CONTROL}: begin
                    state_next.match_enable = wbyte[ABU_BIT_MATCH_ENABLE]; // [RL8]
                    if (!wbyte[ABU_BIT_ACTIVE]) begin
                        state_next.active_flag = 1'b0; // [RL7]
                    end else begin
                        // No forced break while stopped; the register write still lands
                        sw_force = !stop_mode; // [RL6] [RL14]
                    end
                end
                {4'h0, ABU_OFF_ADDR_HIGH}: state_next.addr_high = wbyte; // [RL9]
                {4'h0, ABU_OFF_ADDR_LOW}: state_next.addr_low = wbyte; // [RL9]
                {4'h0, ABU_OFF_FLAG_CLEAR}:
                    state_next.flag_clear_enable = wbyte[ABU_BIT_FLAG_CLEAR_ENABLE];
                ABU_OFF_WAKE: begin
                    if (!wbyte[ABU_BIT_WAKE]) begin
                        state_next.wake_flag = 1'b0; // [RL16]
                    end
                end
                ABU_OFF_IRQ_MASK: state_next.irq_mask = wbyte[1:0];
                default: begin
                end
            endcase
        end
        // AXI read channel; a read of interrupt status clears it
        do_read = s_axi_arvalid && state_reg.arready;
        if (do_read) begin
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rresp = mapped(s_axi_araddr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
            state_next.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                {4'h0, ABU_OFF_STATUS_CONTROL}:
                    state_next.rdata[7:6] = {state_reg.match_enable, state_reg.active_flag};
                {4'h0, ABU_OFF_ADDR_HIGH}: state_next.rdata[7:0] = state_reg.addr_high;
                {4'h0, ABU_OFF_ADDR_LOW}: state_next.rdata[7:0] = state_reg.addr_low;
                {4'h0, ABU_OFF_FLAG_CLEAR}:
                    state_next.rdata[ABU_BIT_FLAG_CLEAR_ENABLE] = state_reg.flag_clear_enable;
                ABU_OFF_WAKE: state_next.rdata[ABU_BIT_WAKE] = state_reg.wake_flag;
                ABU_OFF_IRQ_STATUS: begin
                    state_next.rdata[1:0] = state_reg.irq_status;
                    state_next.irq_status = ABU_RESET_IRQ;
                end
                ABU_OFF_IRQ_MASK: state_next.rdata[1:0] = state_reg.irq_mask;
                default: begin
                end
            endcase
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
            state_next.arready = 1'b1;
        end
        // Registered comparison; held off in stop mode, live in wait mode [RL18] [RL14] [RL13]
        state_next.match_hit = state_reg.match_enable && cpu_pc_fetch && !stop_mode
            && (cpu_address == {state_reg.addr_high, state_reg.addr_low}); // [RL1] [RL2]
        state_next.last_hit = cpu_last_cycle;
        trigger = (state_reg.match_hit && state_reg.state == ABU_IDLE) || sw_force;
        case (state_reg.state)
            ABU_IDLE: begin
                if (trigger) begin
                    state_next.state = ABU_REQUEST; // [RL19]
                    if (state_reg.match_hit) begin
                        state_next.active_flag = 1'b1; // [RL7]
                    end
                    // Vector picked at request so the core sees it before its fetch [RL4]
                    state_next.vector = monitor_mode ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL;
                    if (wait_mode || stop_mode) begin
                        state_next.wake_flag = 1'b1; // [RL16]
                        state_next.irq_status[ABU_IRQ_BIT_WAKE] = 1'b1;
                    end
                    state_next.irq_status[ABU_IRQ_BIT_BREAK] = 1'b1;
                end
            end
            ABU_REQUEST: begin
                // Core completes its instruction, then acks with the opcode swap [RL3] [RL5]
                if (cpu_break_ack) begin
                    state_next.state = ABU_IN_BREAK;
                end
            end
            ABU_IN_BREAK: begin
                if (cpu_return_from_interrupt) begin
                    state_next.state = ABU_IDLE; // [RL10]
                end
            end
            default: state_next.state = ABU_IDLE;
        endcase
        state_next.request = (state_next.state == ABU_REQUEST); // [RL18]
        state_next.break_on = (state_next.state == ABU_IN_BREAK);
        state_next.timer_halt = state_next.break_on; // [RL11]
        state_next.cop_disable = state_next.break_on && state_next.hv_level; // [RL12]
        // Protection stops only new clears; latched clears and two-step ones are kept [RL15] [RL17]
        state_next.clear_allowed = (state_next.state != ABU_IN_BREAK)
            || state_next.flag_clear_enable;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.awready <= 1'b1;
            state_reg.wready <= 1'b1;
            state_reg.arready <= 1'b1;
            state_reg.clear_allowed <= 1'b1;
            state_reg.state <= ABU_IDLE;
            state_reg.vector <= ABU_VECTOR_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign break_request = state_reg.request; // [RL18]
    assign break_vector = state_reg.vector;
    assign break_in_progress = state_reg.break_on;
    assign timer_module_halt = state_reg.timer_halt;
    assign supervisory_watchdog_disable = state_reg.cop_disable;
    assign break_flag_clear_allowed = state_reg.clear_allowed;
    assign irq = state_reg.irq;
endmodule

// ==== rtl/abu_pkg.sv ====
// Package with register map, bit positions, reset values and vectors for the breakpoint unit
package abu_pkg;
    localparam logic [3:0] ABU_OFF_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ABU_OFF_ADDR_HIGH = 4'h4;
    localparam logic [3:0] ABU_OFF_ADDR_LOW = 4'h8;
    localparam logic [3:0] ABU_OFF_FLAG_CLEAR = 4'hC;
    localparam logic [7:0] ABU_OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ABU_OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] ABU_OFF_WAKE = 8'h10;
    localparam int ABU_BIT_MATCH_ENABLE = 7;
    localparam int ABU_BIT_ACTIVE = 6;
    localparam int ABU_BIT_FLAG_CLEAR_ENABLE = 7;
    localparam int ABU_BIT_WAKE = 1;
    localparam int ABU_IRQ_BIT_BREAK = 0;
    localparam int ABU_IRQ_BIT_WAKE = 1;
    localparam logic [7:0] ABU_RESET_BYTE = 8'h00;
    localparam logic [1:0] ABU_RESET_IRQ = 2'h0;
    localparam logic [15:0] ABU_VECTOR_NORMAL = 16'hFFFC;
    localparam logic [15:0] ABU_VECTOR_MONITOR = 16'hFEFC;
    localparam logic [1:0] ABU_RESP_OKAY = 2'h0;
    localparam logic [1:0] ABU_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ABU_IDLE, ABU_REQUEST, ABU_IN_BREAK} abu_state_t;
endpackage

// ==== testbench/abu_checker.sv ====
// Property checks bound to the breakpoint unit ports
module abu_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cpu_break_ack,
    input wire logic cpu_return_from_interrupt,
    input wire logic monitor_mode,
    input wire logic stop_mode,
    input wire logic high_test_voltage,
    input wire logic break_request,
    input wire logic [15:0] break_vector,
    input wire logic break_in_progress,
    input wire logic timer_module_halt,
    input wire logic supervisory_watchdog_disable,
    input wire logic break_flag_clear_allowed
);
    import abu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_HOLD: assert property (break_request && !cpu_break_ack |=> break_request)
        else $error("break request dropped before ack");
    AST_ENTRY: assert property (break_request && cpu_break_ack |->
        ##[1:2] break_in_progress) else $error("no break state after ack");
    AST_VEC: assert property ($rose(break_request) |->
        break_vector == (monitor_mode ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL))
        else $error("wrong break vector");
    AST_RTI: assert property (break_in_progress && cpu_return_from_interrupt |->
        ##[1:2] !break_in_progress) else $error("break not ended by return");
    AST_TIMER: assert property (timer_module_halt == break_in_progress)
        else $error("timer halt wrong");
    AST_CLEAR: assert property (!break_in_progress && !$past(break_in_progress) |->
        break_flag_clear_allowed) else $error("flags locked outside break");
    AST_WDOG: assert property (!high_test_voltage [*6] |->
        !supervisory_watchdog_disable) else $error("watchdog off without test voltage");
    AST_STOP: assert property (stop_mode [*3] |-> !$rose(break_request))
        else $error("break raised in stop mode");
endmodule
bind abu_address_breakpoint_unit abu_checker abu_checker_inst (.*);

// ==== testbench/abu_cpu_model.sv ====
// Behavioural core: fetch stream, break entry and return
module abu_cpu_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic run,
    input wire logic [15:0] start_pc,
    input wire logic [15:0] data_addr,
    input wire logic [3:0] ack_wait,
    input wire logic rti_req,
    input wire logic break_request,
    output logic [15:0] cpu_address,
    output logic cpu_pc_fetch,
    output logic cpu_last_cycle,
    output logic cpu_break_ack,
    output logic cpu_return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pc;
    logic [3:0] cnt;
    logic fetch;
    assign fetch = run && !cpu_last_cycle && !break_request;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pc <= 16'h0;
            cnt <= 4'h0;
            cpu_address <= 16'h0;
            cpu_pc_fetch <= 1'h0;
            cpu_last_cycle <= 1'h0;
            cpu_break_ack <= 1'h0;
            cpu_return_from_interrupt <= 1'h0;
        end else begin
            cpu_last_cycle <= !cpu_last_cycle;
            cpu_pc_fetch <= fetch;
            // Operand cycles show another address, which must never break
            cpu_address <= fetch ? pc : data_addr;
            pc <= run ? pc + {15'h0, fetch} : start_pc;
            cpu_return_from_interrupt <= rti_req;
            // Slow or prompt entry after the current instruction
            cnt <= (break_request && !cpu_break_ack) ? cnt + 4'h1 : 4'h0;
            cpu_break_ack <= break_request && !cpu_break_ack && cnt == ack_wait;
        end
    end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the address breakpoint unit
module tb;
    import abu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, resetn = 1'h0, run = 1'h0, rti_req = 1'h0;
    logic [3:0] s_axi_wstrb = 4'hF, ack_wait = 4'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] cpu_address, break_vector, start_pc = 16'h0, data_addr = 16'h0, a;
    logic cpu_pc_fetch, cpu_last_cycle, cpu_break_ack, cpu_return_from_interrupt;
    logic monitor_mode = 1'h0, wait_mode = 1'h0, stop_mode = 1'h0, high_test_voltage = 1'h0;
    logic break_request, break_in_progress, timer_module_halt, irq;
    logic supervisory_watchdog_disable, break_flag_clear_allowed;
    int n_mismatch = 0;
    int num_checks = 0;
    abu_address_breakpoint_unit abu_address_breakpoint_unit_inst (.*);
    abu_cpu_model abu_cpu_model_inst (.*);
    initial begin
        forever #4 clock = ~clock;
    end
    function automatic logic [1:0] exp_resp(input logic [7:0] ad);
        return (ad <= 8'h18 && ad[1:0] == 2'h0) ? 2'h0 : 2'h2;
    endfunction
    function automatic logic [15:0] exp_vec(input logic mon);
        return mon ? 16'hFEFC : 16'hFFFC;
    endfunction
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'h1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: value differs", $time);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp === exp_resp(ad));
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp === exp_resp(ad) && s_axi_rdata === exp);
        @(posedge clock);
    endtask
    task automatic wait_on(ref logic s, input logic exp);
        repeat (16) begin
            if (s === exp) break;
            @(posedge clock);
        end
        chk(s === exp);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clock);
            chk(break_request === 1'h0);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        void'($urandom(75503));
        a = 16'($urandom_range(32'hFFF0, 32'h0100));
        data_addr <= a;
        start_pc <= a + 16'h40;
        repeat (2) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        chk(break_vector === exp_vec(1'h0) && break_flag_clear_allowed === 1'h1);
        for (int i = 0; i <= 8'h18; i += 4) rd(8'(i), 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h20, 8'hFF);
        wr(8'h04, a[15:8]);
        wr(8'h08, a[7:0]);
        rd(8'h04, {24'h0, a[15:8]});
        rd(8'h08, {24'h0, a[7:0]});
        wr(8'h00, 8'h80);
        rd(8'h00, 32'h80);
        run <= 1'h1;
        quiet(20);
        run <= 1'h0;
        start_pc <= a - 16'h3;
        ack_wait <= 4'($urandom_range(3, 0));
        @(posedge clock);
        run <= 1'h1;
        wait_on(break_request, 1'h1);
        chk(break_vector === exp_vec(1'h0));
        run <= 1'h0;
        wait_on(break_in_progress, 1'h1);
        chk(timer_module_halt === 1'h1 && irq === 1'h0);
        chk(break_flag_clear_allowed === 1'h0);
        high_test_voltage <= 1'h1;
        wait_on(supervisory_watchdog_disable, 1'h1);
        rd(8'h00, 32'hC0);
        wr(8'h00, 8'h80);
        rd(8'h00, 32'h80);
        wr(8'h18, 8'h03);
        wait_on(irq, 1'h1);
        rd(8'h14, 32'h1);
        wait_on(irq, 1'h0);
        rti_req <= 1'h1;
        @(posedge clock);
        rti_req <= 1'h0;
        wait_on(break_in_progress, 1'h0);
        wait_on(supervisory_watchdog_disable, 1'h0);
        monitor_mode <= 1'h1;
        wait_mode <= 1'h1;
        wr(8'h0C, 8'h80);
        rd(8'h0C, 32'h80);
        wr(8'h00, 8'h40);
        wait_on(break_request, 1'h1);
        chk(break_vector === exp_vec(1'h1));
        wait_on(break_in_progress, 1'h1);
        chk(break_flag_clear_allowed === 1'h1);
        rd(8'h10, 32'h2);
        rd(8'h14, 32'h3);
        wr(8'h10, 8'h00);
        rd(8'h10, 32'h0);
        rti_req <= 1'h1;
        @(posedge clock);
        rti_req <= 1'h0;
        wait_on(break_in_progress, 1'h0);
        wait_mode <= 1'h0;
        stop_mode <= 1'h1;
        repeat (4) @(posedge clock);
        wr(8'h00, 8'h40);
        quiet(20);
        rd(8'h04, {24'h0, a[15:8]});
        wr(8'h00, 8'h80);
        resetn <= 1'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        chk(break_request === 1'h0 && break_vector === exp_vec(1'h0));
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        wrap_up();
    end
endmodule
